// File: src/dbas_pkg.sv
package dbas_pkg;

  // ************************************************************
  // debug command codes
  // ************************************************************
  localparam logic [7:0] CMD_READ_REV = 8'h00;
  localparam logic [7:0] CMD_READ_STATUS = 8'h02;
  localparam logic [7:0] CMD_READ_RUNTIME = 8'h03;
  localparam logic [7:0] CMD_WRITE_PC = 8'h06;
  localparam logic [7:0] CMD_READ_PC = 8'h07;
  localparam logic [7:0] CMD_WRITE_REG = 8'h08;
  localparam logic [7:0] CMD_READ_REG = 8'h09;
  localparam logic [7:0] CMD_WRITE_PMEM = 8'h0A;
  localparam logic [7:0] CMD_READ_PMEM = 8'h0B;
  localparam logic [7:0] CMD_WRITE_DMEM = 8'h0C;
  localparam logic [7:0] CMD_READ_DMEM = 8'h0D;
  localparam logic [7:0] CMD_READ_CRC = 8'h0E;
  localparam logic [7:0] CMD_RSVD_0F = 8'h0F;
  localparam logic [7:0] CMD_STEP = 8'h10;
  localparam logic [7:0] CMD_STUFF = 8'h11;
  localparam logic [7:0] CMD_EXECUTE = 8'h12;
  localparam logic [7:0] CMD_LAST_USED = 8'h12;

  // ************************************************************
  // debugger status register layout
  // ************************************************************
  localparam int ST_DEBUG_BIT = 7;
  localparam int ST_HALT_BIT = 6;
  localparam int ST_RP_HONORED_BIT = 5;
  localparam logic [4:0] ST_RSVD_VALUE = 5'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  // ************************************************************
  // runtime counter and trim bytes
  // ************************************************************
  localparam logic [15:0] RUNTIME_ZERO = 16'h0000;
  localparam logic [15:0] RUNTIME_MAX = 16'hFFFF;
  localparam logic [15:0] RUNTIME_ONE = 16'h0001;
  localparam int TRIM_AW = 3;
  localparam int TRIM_DEPTH = 8;
  localparam logic [7:0] TRIM_INFO_OFFSET = 8'h20;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [11:0] ADDR_ZERO = 12'h000;

  typedef enum logic [1:0] {
    DBAS_IDLE = 2'b00,
    DBAS_SEND_HI = 2'b01,
    DBAS_SEND_LO = 2'b10
  } dbas_st_t;

  typedef struct packed {
    logic [7:0] code;
    logic [11:0] addr;
    logic [7:0] data;
  } dbas_cmd_t;

  typedef struct packed {
    dbas_st_t st;
    logic [7:0] ans_lo;
    logic [7:0] tx_data;
    logic [15:0] rt_cnt;
    logic halt_d;
    logic [7:0] status;
    logic fwd_valid;
    dbas_cmd_t fwd;
    logic refuse;
    logic [7:0] trim_rdata;
    logic [7:0] trim_info_addr;
  } dbas_state_t;

endpackage

// File: src/dbas_top.sv
// Summary of operation
// RULE1: protected: refuse pc, register read, program, step, stuff, execute
// RULE2: protected register writes pass only to flash registers
// RULE3: protected flash control write takes mass erase only
// RULE4: data read and checksum read always usable
// RULE5: revision command answers major byte then minor
// RULE6: status command answers one status byte
// RULE7: runtime counter counts cycles between breakpoints, readable
// RULE8: sixteen bits, from zero, saturates at all ones
// RULE9: write memory commands overwrite the runtime counter
// RULE10: status bit 7 shows debug mode
// RULE11: status bit 6 shows halt mode
// RULE12: status bit 5 low when protect gating active
// RULE13: bits 4..0 zero, read only, reset zero
// RULE14: host must not alter reserved trim bytes
// RULE15: trim bytes survive reset, fully read write
// RULE16: trim byte sits at info page address plus 20h
// RULE17: protect bit zero blocks, one enables everything
// RULE18: reserved command codes change nothing
module dbas_top #(
  parameter logic [15:0] DEBUGGER_REVISION = 16'h0100,
  parameter logic [11:0] FLASH_REG_LO = 12'hFF8,
  parameter logic [11:0] FLASH_REG_HI = 12'hFFD,
  parameter logic [11:0] FLASH_CTRL_ADDR = 12'hFF8,
  parameter logic [7:0] MASS_ERASE_CODE = 8'h63
) (
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic CE,
  input wire logic CMD_VALID,
  output logic CMD_READY,
  input wire dbas_pkg::dbas_cmd_t CMD,
  output logic FWD_VALID,
  output dbas_pkg::dbas_cmd_t FWD,
  output logic REFUSE,
  output logic TX_VALID,
  input wire logic TX_READY,
  output logic [7:0] TX_DATA,
  input wire logic DEBUG_MODE,
  input wire logic HALT_MODE,
  input wire logic FLASH_READ_PROTECT,
  input wire logic PROTECT_GATE_EN,
  output logic [7:0] STATUS,
  input wire logic TRIM_REQ,
  input wire logic TRIM_WE,
  input wire logic [dbas_pkg::TRIM_AW-1:0] TRIM_ADDR,
  input wire logic [7:0] TRIM_WDATA,
  output logic [7:0] TRIM_RDATA,
  output logic [7:0] TRIM_INFO_ADDR
);
  import dbas_pkg::*;

  // ************************************************************
  // gating decode
  // ************************************************************
  function automatic logic is_reserved(input logic [7:0] code);
    return (code == CMD_RSVD_0F) || (code > CMD_LAST_USED);
  endfunction

  // read protection blocks these outright
  function automatic logic is_blocked(input logic [7:0] code);
    return (code == CMD_WRITE_PC) || (code == CMD_READ_PC) ||
           (code == CMD_READ_REG) || (code == CMD_WRITE_PMEM) ||
           (code == CMD_READ_PMEM) || (code == CMD_STEP) ||
           (code == CMD_STUFF) || (code == CMD_EXECUTE);
  endfunction

  function automatic logic is_refused(input dbas_cmd_t c, input logic prot);
    logic flash_reg;
    flash_reg = (c.addr >= FLASH_REG_LO) && (c.addr <= FLASH_REG_HI);
    if (!prot) begin
      return 1'b0; // RULE17
    end else if (is_blocked(c.code)) begin
      return 1'b1; // RULE1
    end else if (c.code == CMD_WRITE_REG) begin
      if (!flash_reg) begin
        return 1'b1; // RULE2
      end else if (c.addr == FLASH_CTRL_ADDR) begin
        return c.data != MASS_ERASE_CODE; // RULE3
      end else begin
        return 1'b0;
      end
    end else begin
      return 1'b0; // RULE4
    end
  endfunction

  dbas_state_t s_r;
  dbas_state_t s_nxt;
  logic [7:0] trim_mem [TRIM_DEPTH];
  logic protect_active;
  logic take;

  // protection only bites when the option bit is programmed and gating is on
  assign protect_active = PROTECT_GATE_EN && !FLASH_READ_PROTECT; // RULE17
  assign CMD_READY = CE && (s_r.st == DBAS_IDLE);
  assign take = CMD_VALID && CMD_READY;
  assign TX_VALID = (s_r.st != DBAS_IDLE);
  assign TX_DATA = s_r.tx_data;
  assign FWD_VALID = s_r.fwd_valid;
  assign FWD = s_r.fwd;
  assign REFUSE = s_r.refuse;
  assign STATUS = s_r.status;
  assign TRIM_RDATA = s_r.trim_rdata;
  assign TRIM_INFO_ADDR = s_r.trim_info_addr;

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    s_nxt = s_r;
    s_nxt.fwd_valid = 1'b0;
    s_nxt.refuse = 1'b0;
    s_nxt.halt_d = HALT_MODE;
    // status is sampled every cycle that CE is high; the host can never write it
    s_nxt.status[ST_DEBUG_BIT] = DEBUG_MODE; // RULE10
    s_nxt.status[ST_HALT_BIT] = HALT_MODE; // RULE11
    s_nxt.status[ST_RP_HONORED_BIT] = !PROTECT_GATE_EN; // RULE12
    s_nxt.status[4:0] = ST_RSVD_VALUE; // RULE13
    // restart after a breakpoint begins a fresh interval
    if (s_r.halt_d && !HALT_MODE) begin
      s_nxt.rt_cnt = RUNTIME_ZERO; // RULE8
    end else if (!HALT_MODE && (s_r.rt_cnt != RUNTIME_MAX)) begin
      s_nxt.rt_cnt = s_r.rt_cnt + RUNTIME_ONE; // RULE7 RULE8
    end
    case (s_r.st)
      DBAS_IDLE: begin
        if (take) begin
          if (CMD.code == CMD_READ_REV) begin
            s_nxt.tx_data = DEBUGGER_REVISION[15:8]; // RULE5
            s_nxt.ans_lo = DEBUGGER_REVISION[7:0];
            s_nxt.st = DBAS_SEND_HI;
          end else if (CMD.code == CMD_READ_STATUS) begin
            s_nxt.tx_data = s_r.status; // RULE6
            s_nxt.st = DBAS_SEND_LO;
          end else if (CMD.code == CMD_READ_RUNTIME) begin
            s_nxt.tx_data = s_r.rt_cnt[15:8]; // RULE7
            s_nxt.ans_lo = s_r.rt_cnt[7:0];
            s_nxt.st = DBAS_SEND_HI;
          end else if (is_reserved(CMD.code)) begin
            s_nxt.st = DBAS_IDLE; // RULE18
          end else if (is_refused(CMD, protect_active)) begin
            s_nxt.refuse = 1'b1; // RULE1
          end else begin
            s_nxt.fwd_valid = 1'b1;
            s_nxt.fwd = CMD;
            // the memory write path borrows the counter as scratch
            if ((CMD.code == CMD_WRITE_PMEM) || (CMD.code == CMD_WRITE_DMEM)) begin
              s_nxt.rt_cnt = RUNTIME_ZERO; // RULE9
            end
          end
        end
      end
      DBAS_SEND_HI: begin
        if (TX_READY) begin
          s_nxt.tx_data = s_r.ans_lo; // RULE5
          s_nxt.st = DBAS_SEND_LO;
        end
      end
      DBAS_SEND_LO: begin
        if (TX_READY) begin
          s_nxt.st = DBAS_IDLE;
        end
      end
      default: begin
        s_nxt.st = DBAS_IDLE;
      end
    endcase
    if (TRIM_REQ) begin
      s_nxt.trim_info_addr = TRIM_INFO_OFFSET + {5'h00, TRIM_ADDR}; // RULE16
      s_nxt.trim_rdata = TRIM_WE ? TRIM_WDATA : trim_mem[TRIM_ADDR]; // RULE15
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      s_r <= '{st: DBAS_IDLE, ans_lo: BYTE_ZERO, tx_data: BYTE_ZERO,
               rt_cnt: RUNTIME_ZERO, halt_d: 1'b0, status: STATUS_RESET,
               fwd_valid: 1'b0, fwd: '{code: BYTE_ZERO, addr: ADDR_ZERO,
               data: BYTE_ZERO}, refuse: 1'b0, trim_rdata: BYTE_ZERO,
               trim_info_addr: BYTE_ZERO}; // RULE13
    end else if (CE) begin
      s_r <= s_nxt;
    end
  end

  // trim store has no reset on purpose: it models nonvolatile cells
  always_ff @(posedge SYS_CLK) begin
    if (CE && TRIM_REQ && TRIM_WE) begin
      trim_mem[TRIM_ADDR] <= TRIM_WDATA; // RULE15
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);

  a_refuse_blocked: assert property ( // RULE1
    take && protect_active && is_blocked(CMD.code) |=> REFUSE && !FWD_VALID)
    else $error("blocked command not refused");

  a_wreg_other: assert property ( // RULE2
    take && protect_active && (CMD.code == CMD_WRITE_REG) &&
    ((CMD.addr < FLASH_REG_LO) || (CMD.addr > FLASH_REG_HI)) |=> !FWD_VALID)
    else $error("protected register write leaked");

  a_flash_ctrl_code: assert property ( // RULE3
    take && protect_active && (CMD.code == CMD_WRITE_REG) &&
    (CMD.addr == FLASH_CTRL_ADDR) |=> FWD_VALID == ($past(CMD.data) == MASS_ERASE_CODE))
    else $error("flash control write gated wrongly");

  a_dmem_open: assert property ( // RULE4
    take && ((CMD.code == CMD_READ_DMEM) || (CMD.code == CMD_READ_CRC))
    |=> FWD_VALID && !REFUSE)
    else $error("data read or checksum refused");

  a_rev_first: assert property ( // RULE5
    take && (CMD.code == CMD_READ_REV) |=> TX_VALID && (TX_DATA == DEBUGGER_REVISION[15:8]))
    else $error("revision major byte wrong");

  // the low byte follows only once the host has taken the high one
  a_rev_second: assert property ( // RULE5
    CE && TX_READY && (s_r.st == DBAS_SEND_HI) |=> TX_VALID && (TX_DATA == $past(s_r.ans_lo)))
    else $error("second answer byte wrong");

  a_stat_reply: assert property ( // RULE6
    take && (CMD.code == CMD_READ_STATUS) |=> TX_VALID && (TX_DATA == $past(STATUS)))
    else $error("status answer wrong");

  a_rt_count: assert property ( // RULE7
    CE && !HALT_MODE && !s_r.halt_d && !take && (s_r.rt_cnt != RUNTIME_MAX)
    |=> s_r.rt_cnt == $past(s_r.rt_cnt) + RUNTIME_ONE)
    else $error("runtime counter missed a cycle");

  a_rt_saturate: assert property ( // RULE8
    CE && !take && !(s_r.halt_d && !HALT_MODE) && (s_r.rt_cnt == RUNTIME_MAX)
    |=> s_r.rt_cnt == RUNTIME_MAX)
    else $error("runtime counter wrapped");

  a_rt_overwrite: assert property ( // RULE9
    take && (CMD.code == CMD_WRITE_DMEM) |=> s_r.rt_cnt == RUNTIME_ZERO)
    else $error("write memory kept runtime count");

  a_status_bits: assert property ( // RULE10 RULE11 RULE12 RULE13
    CE |=> (STATUS[4:0] == ST_RSVD_VALUE) && (STATUS[ST_DEBUG_BIT] == $past(DEBUG_MODE))
    && (STATUS[ST_HALT_BIT] == $past(HALT_MODE))
    && (STATUS[ST_RP_HONORED_BIT] == !$past(PROTECT_GATE_EN)))
    else $error("status bits wrong");

  a_trim_map: assert property ( // RULE16
    CE && TRIM_REQ |=> TRIM_INFO_ADDR == TRIM_INFO_OFFSET + {5'h00, $past(TRIM_ADDR)})
    else $error("trim info address wrong");

  a_rsvd_ignore: assert property ( // RULE18
    take && is_reserved(CMD.code) |=> !FWD_VALID && !REFUSE && !TX_VALID &&
    (s_r.fwd == $past(s_r.fwd)))
    else $error("reserved command had an effect");

  // ************************************************************
  // answer and forwarding checks
  // ************************************************************

  a_open_fwd: assert property ( // RULE17
    take && !protect_active && !is_reserved(CMD.code) && (CMD.code != CMD_READ_REV) &&
    (CMD.code != CMD_READ_STATUS) && (CMD.code != CMD_READ_RUNTIME)
    |=> FWD_VALID && !REFUSE)
    else $error("open command not forwarded");

  a_open_norefuse: assert property ( // RULE17
    take && !protect_active |=> !REFUSE)
    else $error("refusal without protection");

  a_wreg_flash: assert property ( // RULE2
    take && protect_active && (CMD.code == CMD_WRITE_REG) && (CMD.addr != FLASH_CTRL_ADDR) &&
    (CMD.addr >= FLASH_REG_LO) && (CMD.addr <= FLASH_REG_HI) |=> FWD_VALID)
    else $error("flash register write blocked");

  a_ctrl_refuse: assert property ( // RULE3
    take && protect_active && (CMD.code == CMD_WRITE_REG) && (CMD.addr == FLASH_CTRL_ADDR) &&
    (CMD.data != MASS_ERASE_CODE) |=> REFUSE)
    else $error("other flash command not refused");

  a_fwd_copy: assert property ( // RULE4
    take && (CMD.code == CMD_READ_DMEM) |=> FWD == $past(CMD))
    else $error("forwarded command corrupted");

  a_fwd_hold: assert property ( // RULE4
    CE && !take |=> FWD == $past(FWD))
    else $error("forwarded copy changed");

  a_busy_ready: assert property ( // RULE5
    TX_VALID |-> !CMD_READY)
    else $error("command taken during answer");

  a_idle_ready: assert property ( // RULE5
    CE && !TX_VALID |-> CMD_READY)
    else $error("idle but not ready");

  a_stat_once: assert property ( // RULE6
    take && (CMD.code == CMD_READ_STATUS) ##1 (CE && TX_READY) |=> !TX_VALID)
    else $error("status answer too long");

  a_rt_high: assert property ( // RULE7
    take && (CMD.code == CMD_READ_RUNTIME) |=> TX_DATA == $past(s_r.rt_cnt[15:8]))
    else $error("runtime high byte wrong");

  a_rsvd_ready: assert property ( // RULE18
    take && is_reserved(CMD.code) |=> CMD_READY || !CE)
    else $error("reserved command stalled");

  // ************************************************************
  // runtime counter checks
  // ************************************************************

  a_rt_halted: assert property ( // RULE7
    CE && HALT_MODE && !take
    |=> s_r.rt_cnt == $past(s_r.rt_cnt))
    else $error("runtime counted while halted");

  a_rt_restart: assert property ( // RULE8
    CE && s_r.halt_d && !HALT_MODE |=> s_r.rt_cnt == RUNTIME_ZERO)
    else $error("runtime not restarted");

  a_rt_pmem: assert property ( // RULE9
    take && !protect_active && (CMD.code == CMD_WRITE_PMEM) |=> s_r.rt_cnt == RUNTIME_ZERO)
    else $error("program write kept runtime count");

  // ************************************************************
  // trim and freeze checks
  // ************************************************************

  a_trim_echo: assert property ( // RULE15
    CE && TRIM_REQ && TRIM_WE |=> TRIM_RDATA == $past(TRIM_WDATA))
    else $error("trim write not echoed");

  a_trim_hold: assert property ( // RULE16
    CE && !TRIM_REQ |=> $stable(TRIM_INFO_ADDR))
    else $error("trim address moved");

  a_ce_freeze: assert property ( // RULE13
    !CE |=> s_r == $past(s_r))
    else $error("state moved with enable low");

endmodule // dbas_top

// File: testbench/dbas_host_model.sv
// ************************************************************
// host debug tool: takes answer bytes, optionally stalling
// ************************************************************
module dbas_host_model (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic slow,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got [$];
  logic ph = 1'b0;
  initial tx_ready = 1'b0;
  always @(posedge sys_clk) begin
    if (tx_valid && tx_ready) got.push_back(tx_data);
    ph <= ~ph;
    // slow mode accepts only every other cycle
    tx_ready <= !reset && (!slow || ph);
  end
endmodule // dbas_host_model

// File: testbench/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dbas_pkg::*;
  logic sys_clk = 0, reset = 1, ce = 1, cmd_valid = 0, dbg = 1, halt = 1, flash_read_protect = 0, gate = 0;
  logic trim_req = 0, trim_we = 0, slow = 0, cmd_ready, fwd_valid, refuse, tx_valid, tx_ready;
  logic [2:0] trim_addr = 0;
  logic [7:0] trim_wdata = 0, tx_data, status, trim_rdata, trim_info;
  dbas_cmd_t cmd = '0, fwd;
  int err_total = 0, checks_done = 0;
  int unsigned cyc = 0;
  logic [15:0] v1, v2;
  int unsigned t1, t2;
  logic [28:0] tbl [15] = '{{1'b0, 8'h06, 20'h0}, {1'b0, 8'h07, 20'h0}, {1'b0, 8'h09, 20'h0},
    {1'b0, 8'h0A, 20'h0}, {1'b0, 8'h0B, 20'h0}, {1'b0, 8'h10, 20'h0}, {1'b0, 8'h11, 20'h0},
    {1'b0, 8'h12, 20'h0}, {1'b1, 8'h0C, 20'h0}, {1'b1, 8'h0D, 20'h0}, {1'b1, 8'h0E, 20'h0},
    {1'b0, 8'h08, 20'h00055}, {1'b1, 8'h08, 20'hFF955}, {1'b1, 8'h08, 20'hFF863},
    {1'b0, 8'h08, 20'hFF862}};
  dbas_top u_dbas_top (.SYS_CLK(sys_clk), .RESET(reset), .CE(ce), .CMD_VALID(cmd_valid),
    .CMD_READY(cmd_ready), .CMD(cmd), .FWD_VALID(fwd_valid), .FWD(fwd), .REFUSE(refuse),
    .TX_VALID(tx_valid), .TX_READY(tx_ready), .TX_DATA(tx_data), .DEBUG_MODE(dbg),
    .HALT_MODE(halt), .FLASH_READ_PROTECT(flash_read_protect), .PROTECT_GATE_EN(gate), .STATUS(status),
    .TRIM_REQ(trim_req), .TRIM_WE(trim_we), .TRIM_ADDR(trim_addr), .TRIM_WDATA(trim_wdata),
    .TRIM_RDATA(trim_rdata), .TRIM_INFO_ADDR(trim_info));
  dbas_host_model u_dbas_host_model (.sys_clk(sys_clk), .reset(reset), .slow(slow),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
  always #12.5 sys_clk = ~sys_clk;
  task automatic close_out();
    if (err_total == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      err_total++;
      close_out();
    end
  end
  task automatic chk(input string what, input logic [27:0] exp, input logic [27:0] seen);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // request held until the edge that takes it; t is that edge's cycle
  task automatic issue(input logic [27:0] c, output int unsigned t);
    int n = 0;
    u_dbas_host_model.got.delete();
    @(posedge sys_clk);
    cmd_valid <= 1;
    cmd <= c;
    do begin @(posedge sys_clk); n++; end while (cmd_ready !== 1'b1 && n < 50);
    t = cyc;
    cmd_valid <= 0;
    #1;
  endtask
  task automatic answer(input logic [7:0] c, input int nb, output logic [15:0] v,
                        output int unsigned t);
    int n = 0;
    issue({c, 20'h0}, t);
    while (cmd_ready !== 1'b1 && n < 40) begin @(posedge sys_clk); #1; n++; end
    chk("answer bytes", nb, u_dbas_host_model.got.size());
    v = (nb == 2) ? {u_dbas_host_model.got[0], u_dbas_host_model.got[1]} :
        (nb == 1) ? {8'h00, u_dbas_host_model.got[0]} : 16'h0;
  endtask
  task automatic fwd_case(input logic [27:0] c, input logic ok);
    int unsigned t;
    issue(c, t);
    chk("fwd_valid", ok, fwd_valid);
    chk("refuse", !ok, refuse);
    if (ok) chk("fwd", c, fwd);
  endtask
  task automatic trim(input logic we, input logic [2:0] a, input logic rd_chk);
    @(posedge sys_clk);
    {trim_req, trim_we, trim_addr, trim_wdata} <= {1'b1, we, a, 8'hA0 + a};
    @(posedge sys_clk);
    trim_req <= 0;
    #1;
    if (rd_chk) chk("trim data", 8'hA0 + a, trim_rdata);
    chk("trim info addr", 8'h20 + a, trim_info);
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_status();
    chk("status in reset", 8'h00, status);
    reset <= 0;
    repeat (3) @(posedge sys_clk);
    #1;
    chk("status", 8'hE0, status);
    answer(CMD_READ_STATUS, 1, v1, t1);
    chk("status answer", 8'hE0, v1);
    {dbg, halt, gate} <= 3'b001;
    repeat (3) @(posedge sys_clk);
    #1;
    chk("status low", 8'h00, status);
  endtask
  task automatic t_rev();
    slow <= 1;
    answer(CMD_READ_REV, 2, v1, t1);
    chk("revision", 16'h0100, v1);
    slow <= 0;
  endtask
  task automatic t_protect();
    foreach (tbl[i]) fwd_case(tbl[i][27:0], tbl[i][28]);
    flash_read_protect <= 1;
    fwd_case({CMD_WRITE_PC, 20'h0}, 1'b1);
    {gate, flash_read_protect} <= 2'b00;
    fwd_case({CMD_READ_REG, 20'h0}, 1'b1);
  endtask
  task automatic t_runtime();
    answer(CMD_READ_RUNTIME, 2, v1, t1);
    answer(CMD_READ_RUNTIME, 2, v2, t2);
    chk("runtime step", v1 + 16'(t2 - t1), v2);
    fwd_case({CMD_WRITE_DMEM, 20'h0}, 1'b1);
    answer(CMD_READ_RUNTIME, 2, v1, t1);
    chk("runtime cleared", 1'b1, v1 < 16'd16);
    repeat (66000) @(posedge sys_clk);
    answer(CMD_READ_RUNTIME, 2, v1, t1);
    chk("runtime saturated", 16'hFFFF, v1);
    halt <= 1;
    answer(CMD_READ_RUNTIME, 2, v1, t1);
    repeat (5) @(posedge sys_clk);
    answer(CMD_READ_RUNTIME, 2, v2, t2);
    chk("runtime halted", v1, v2);
    halt <= 0;
    answer(CMD_READ_RUNTIME, 2, v1, t1);
    chk("runtime from zero", 1'b1, v1 < 16'd16);
  endtask
  task automatic t_reserved();
    logic [7:0] rsv [3] = '{8'h0F, 8'h13, 8'hFF};
    int unsigned t;
    foreach (rsv[i]) begin
      issue({rsv[i], 20'h0}, t);
      chk("no forward", 1'b0, fwd_valid);
      chk("no answer", 1'b0, tx_valid);
      chk("no refuse", 1'b0, refuse);
      chk("ready at once", 1'b1, cmd_ready);
    end
    ce <= 0;
    @(posedge sys_clk);
    #1;
    chk("ready with clock off", 1'b0, cmd_ready);
    ce <= 1;
  endtask
  task automatic t_trim();
    logic [2:0] free [5] = '{3'd2, 3'd3, 3'd5, 3'd6, 3'd7};
    logic [2:0] kept [3] = '{3'd0, 3'd1, 3'd4};
    // bytes 0, 1 and 4 are only read, never altered
    foreach (free[i]) trim(1, free[i], 1);
    reset <= 1;
    repeat (2) @(posedge sys_clk);
    reset <= 0;
    foreach (free[i]) trim(0, free[i], 1);
    foreach (kept[i]) trim(0, kept[i], 0);
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    t_status();
    t_rev();
    t_protect();
    t_reserved();
    t_runtime();
    t_trim();
    close_out();
  end
endmodule // tb_top
